// ===== acfh_pkg.sv
package acfh_pkg;

  // printed register offsets, kept as word indices (some are not word aligned)
  localparam logic [6:0] IDX_LAT      = 7'h0D;
  localparam logic [6:0] IDX_HDR      = 7'h0E;
  localparam logic [6:0] IDX_TEST     = 7'h0F;
  localparam logic [6:0] IDX_MWIN     = 7'h10;
  localparam logic [6:0] IDX_SUBSYS   = 7'h2C;
  localparam logic [6:0] IDX_CAPHEAD  = 7'h34;
  localparam logic [6:0] IDX_LEGACY   = 7'h40;
  localparam logic [6:0] IDX_CAPTAG   = 7'h44;
  localparam logic [6:0] IDX_CAPNEXT  = 7'h45;
  localparam logic [6:0] IDX_CAPINFO  = 7'h46;

  // apb byte address width and word shift
  localparam int          ADDR_W      = 12;
  localparam int          WORD_SHIFT  = 2;

  // fixed read-only values
  localparam logic [7:0]  LAT_VALUE       = 8'h00;
  localparam logic [7:0]  HDR_VALUE       = 8'h00;
  localparam logic [7:0]  TEST_VALUE      = 8'h00;
  localparam logic [7:0]  CAPHEAD_VALUE   = 8'h44;
  localparam logic [7:0]  CAPTAG_VALUE    = 8'h10;
  localparam logic [7:0]  CAPNEXT_VALUE   = 8'h6C;
  localparam logic [3:0]  VERSION_VALUE   = 4'h1;
  localparam logic [3:0]  PORT_KIND_VALUE = 4'h0;

  // reset values of writable registers
  localparam logic [19:0] MWIN_RESET      = 20'h00000;
  localparam logic [31:0] SUBSYS_RESET    = 32'h00000000;
  localparam logic [15:0] LEGACY_RESET    = 16'h0000;

  // field positions
  localparam int          MWIN_LSB        = 12;
  localparam int          LEG_EN_BIT      = 15;
  localparam int          LEG_HI_LSB      = 8;
  localparam int          LEG_MID_LSB     = 4;
  localparam int          LEG_LO_LSB      = 0;
  localparam logic [15:0] LEGACY_WMASK    = 16'h8FFF;

  // fixed upper address digits of the legacy range
  localparam logic [11:0] LEGACY_TOP      = 12'hFEC;

  // memory request seen by the decoder
  typedef struct packed {
    logic        valid;  // request present this cycle
    logic [31:0] addr;   // byte address
  } acfh_mreq_t;

  // routing decision handed to the interrupt routing unit
  typedef struct packed {
    logic        hit;     // request claimed
    logic        legacy;  // claimed through the legacy range
    logic        window;  // claimed through the memory window
    logic [11:0] offset;  // offset inside the routing register space
  } acfh_route_t;

endpackage

// ===== acfh_config_header.sv
`timescale 1ns/1ps
module acfh_config_header
  import acfh_pkg::*;
(
  input  wire logic              mclk,       // core clock, 50 MHz
  input  wire logic              sys_rst,    // primary bus reset, async, active high
  input  wire logic              psel,       // apb select
  input  wire logic              penable,    // apb access phase
  input  wire logic              pwrite,     // apb direction, high for write
  input  wire logic [ADDR_W-1:0] paddr,      // apb byte address
  input  wire logic [31:0]       pwdata,     // apb write data
  input  wire logic [3:0]        pstrb,      // apb byte strobes
  output logic      [31:0]       prdata,     // apb read data
  output logic                   pready,     // apb ready
  output logic                   pslverr,    // apb error, unmapped address
  input  wire acfh_mreq_t        mreq,       // memory request from the link
  output acfh_route_t            route       // registered claim and routing offset
);

  // register state
  logic [19:0] mwin_q;          // memory window base address bits
  logic [31:0] subsys_q;        // subsystem part and maker codes
  logic        subsys_done_q;   // write_once_sticky lock
  logic [15:0] legacy_q;        // legacy window base register
  logic [31:0] prdata_q;        // read data flop
  logic        pready_q;        // ready flop
  logic        pslverr_q;       // error flop
  acfh_route_t route_q;         // decode result flop

  // bus decode helpers
  logic        setup_rd;        // setup cycle of any access
  logic        access_wr;       // completing write edge
  logic [6:0]  widx;            // word index from byte address
  logic        mapped;          // address belongs to a register
  logic [31:0] rd_word;         // word assembled for a read
  logic        wr_mwin;         // write hits memory window base
  logic        wr_subsys;       // write hits subsystem identifier
  logic        wr_legacy;       // write hits legacy base

  assign setup_rd  = psel && !penable;
  assign access_wr = psel && penable && pready_q && pwrite && mapped;
  assign widx      = paddr[WORD_SHIFT +: 7];
  assign wr_mwin   = access_wr && (widx == IDX_MWIN);
  assign wr_subsys = access_wr && (widx == IDX_SUBSYS);
  assign wr_legacy = access_wr && (widx == IDX_LEGACY);

  // address map; low address bits must be zero for a word access
  always_comb begin
    mapped  = 1'b0;
    rd_word = 32'h00000000;
    if (paddr[WORD_SHIFT-1:0] != 2'b00) begin
      // misaligned address, left unmapped
      mapped = 1'b0;
    end else if (widx == IDX_LAT) begin
      mapped  = 1'b1;
      rd_word = {24'h000000, LAT_VALUE};
    end else if (widx == IDX_HDR) begin
      mapped  = 1'b1;
      rd_word = {24'h000000, HDR_VALUE};
    end else if (widx == IDX_TEST) begin
      mapped  = 1'b1;
      rd_word = {24'h000000, TEST_VALUE};
    end else if (widx == IDX_MWIN) begin
      mapped  = 1'b1;
      rd_word = {mwin_q, 12'h000};
    end else if (widx == IDX_SUBSYS) begin
      mapped  = 1'b1;
      rd_word = subsys_q;
    end else if (widx == IDX_CAPHEAD) begin
      mapped  = 1'b1;
      rd_word = {24'h000000, CAPHEAD_VALUE};
    end else if (widx == IDX_LEGACY) begin
      mapped  = 1'b1;
      rd_word = {16'h0000, legacy_q & LEGACY_WMASK};
    end else if (widx == IDX_CAPTAG) begin
      mapped  = 1'b1;
      rd_word = {24'h000000, CAPTAG_VALUE};
    end else if (widx == IDX_CAPNEXT) begin
      mapped  = 1'b1;
      rd_word = {24'h000000, CAPNEXT_VALUE};
    end else if (widx == IDX_CAPINFO) begin
      mapped  = 1'b1;
      rd_word = {16'h0000, 2'b00, 5'h00, 1'b0, PORT_KIND_VALUE, VERSION_VALUE};
    end
  end

  // apb answer: data sampled in setup, ready for exactly the access edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (setup_rd) begin
      // reads of unmapped words return zero with an error
      prdata_q  <= pwrite ? 32'h00000000 : rd_word;
      pready_q  <= 1'b1;
      pslverr_q <= !mapped;
    end else begin
      // drop ready after the access edge so a held request is not seen twice
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // memory window base, only bits 31:12 are storage
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mwin_q <= MWIN_RESET;
    end else begin
      if (wr_mwin && pstrb[1]) begin
        mwin_q[3:0] <= pwdata[15:12];
      end
      if (wr_mwin && pstrb[2]) begin
        mwin_q[11:4] <= pwdata[23:16];
      end
      if (wr_mwin && pstrb[3]) begin
        mwin_q[19:12] <= pwdata[31:24];
      end
    end
  end

  // subsystem identifier, write once after the bus reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      subsys_q      <= SUBSYS_RESET;
      subsys_done_q <= 1'b0;
    end else if (wr_subsys && !subsys_done_q) begin
      // first write locks; strobes still pick the bytes
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          subsys_q[8*b +: 8] <= pwdata[8*b +: 8];
        end
      end
      subsys_done_q <= 1'b1;
    end
  end

  // legacy base; reserved bits 14:12 never store
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      legacy_q <= LEGACY_RESET;
    end else begin
      if (wr_legacy && pstrb[0]) begin
        legacy_q[7:0] <= pwdata[7:0];
      end
      if (wr_legacy && pstrb[1]) begin
        legacy_q[15:8] <= pwdata[15:8] & LEGACY_WMASK[15:8];
      end
    end
  end

  // memory decode paths
  logic        hit_window;   // request inside the 4 KB window
  logic        hit_legacy;   // request inside the 256 byte legacy range
  logic [11:0] legacy_mid;   // programmed address bits 19:8

  assign legacy_mid = {legacy_q[LEG_HI_LSB +: 4], legacy_q[LEG_MID_LSB +: 4],
                       legacy_q[LEG_LO_LSB +: 4]};
  assign hit_window = mreq.valid && (mreq.addr[31:MWIN_LSB] == mwin_q);
  assign hit_legacy = mreq.valid && legacy_q[LEG_EN_BIT]
                      && (mreq.addr[31:20] == LEGACY_TOP)
                      && (mreq.addr[19:8] == legacy_mid);

  // claim and route one cycle after the request
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      route_q <= '0;
    end else begin
      route_q.hit    <= hit_window || hit_legacy;
      route_q.legacy <= hit_legacy;
      route_q.window <= hit_window;
      if (hit_window) begin
        route_q.offset <= mreq.addr[11:0];
      end else if (hit_legacy) begin
        route_q.offset <= {4'h0, mreq.addr[7:0]};
      end else begin
        route_q.offset <= 12'h000;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign route   = route_q;

  // checks
  // read checks fire on the setup cycle and look at the access cycle that follows
  // misaligned addresses are left out: they read zero and raise the error flag
  // reset checks run without a disable so that they see the cycle after release
  // decode checks compare against the request of the cycle before, as route is a flop

  a_lat_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (setup_rd && !pwrite && widx == IDX_LAT && paddr[1:0] == 2'b00)
      |=> (prdata == 32'h00000000 && pready))
    else $error("latency timer read not zero");

  a_hdr_fixed: assert property (@(posedge mclk) disable iff (sys_rst)
    (setup_rd && !pwrite && widx == IDX_HDR && paddr[1:0] == 2'b00)
      |=> (prdata == 32'h00000000))
    else $error("header layout value wrong");

  a_test_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (setup_rd && !pwrite && widx == IDX_TEST && paddr[1:0] == 2'b00)
      |=> (prdata == 32'h00000000))
    else $error("self test byte not zero");

  a_mwin_write: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_mwin && pstrb == 4'hF) |=> (mwin_q == $past(pwdata[31:12])))
    else $error("window base write lost");

  a_mwin_reset: assert property (@(posedge mclk)
    $fell(sys_rst) |-> (mwin_q == 20'h00000))
    else $error("window base not cleared");

  a_window_route: assert property (@(posedge mclk) disable iff (sys_rst)
    hit_window |=> (route.hit && route.window && route.offset == $past(mreq.addr[11:0])))
    else $error("window request not routed");

  a_mwin_low: assert property (@(posedge mclk) disable iff (sys_rst)
    (setup_rd && !pwrite && widx == IDX_MWIN && paddr[1:0] == 2'b00)
      |=> (prdata[11:0] == 12'h000))
    else $error("window base low bits not zero");

  a_subsys_reset: assert property (@(posedge mclk)
    $fell(sys_rst) |-> (subsys_q == 32'h00000000 && !subsys_done_q))
    else $error("subsystem identifier not cleared");

  a_subsys_once: assert property (@(posedge mclk) disable iff (sys_rst)
    (subsys_done_q && wr_subsys) |=> $stable(subsys_q))
    else $error("second subsystem write took effect");

  a_subsys_first: assert property (@(posedge mclk) disable iff (sys_rst)
    (!subsys_done_q && wr_subsys && pstrb == 4'hF)
      |=> (subsys_q == $past(pwdata) && subsys_done_q))
    else $error("first subsystem write not taken");

  a_capptr_fixed: assert property (@(posedge mclk) disable iff (sys_rst)
    (setup_rd && !pwrite && widx == IDX_CAPHEAD && paddr[1:0] == 2'b00)
      |=> (prdata == 32'h00000044))
    else $error("capability pointer wrong");

  a_legacy_off: assert property (@(posedge mclk) disable iff (sys_rst)
    (!legacy_q[LEG_EN_BIT] && !hit_window) |=> !route.hit)
    else $error("legacy range claimed while disabled");

  a_legacy_top: assert property (@(posedge mclk) disable iff (sys_rst)
    (mreq.valid && mreq.addr[31:20] != 12'hFEC) |=> !route.legacy)
    else $error("legacy claimed outside its top digits");

  a_legacy_digit: assert property (@(posedge mclk) disable iff (sys_rst)
    (mreq.valid && mreq.addr[19:16] != legacy_q[11:8]) |=> !route.legacy)
    else $error("legacy claimed with wrong high digit");

  a_legacy_lodigit: assert property (@(posedge mclk) disable iff (sys_rst)
    (mreq.valid && mreq.addr[11:8] != legacy_q[3:0]) |=> !route.legacy)
    else $error("legacy claimed with wrong low digit");

  a_legacy_claim: assert property (@(posedge mclk) disable iff (sys_rst)
    (mreq.valid && legacy_q[15] && mreq.addr[31:8] == {12'hFEC, legacy_q[11:0]})
      |=> (route.hit && route.legacy))
    else $error("legacy range match not claimed");

  a_legacy_route: assert property (@(posedge mclk) disable iff (sys_rst)
    (hit_legacy && !hit_window) |=> (route.offset == {4'h0, $past(mreq.addr[7:0])}))
    else $error("legacy offset not routed");

  a_both_paths: assert property (@(posedge mclk) disable iff (sys_rst)
    (hit_window && hit_legacy) |=> (route.window && route.legacy))
    else $error("paths did not decode together");

  a_legacy_rsvd: assert property (@(posedge mclk) disable iff (sys_rst)
    legacy_q[14:12] == 3'b000)
    else $error("legacy reserved bits set");

  a_legacy_reset: assert property (@(posedge mclk)
    $fell(sys_rst) |-> (legacy_q == 16'h0000))
    else $error("legacy base not cleared");

  a_captag_fixed: assert property (@(posedge mclk) disable iff (sys_rst)
    (setup_rd && !pwrite && widx == IDX_CAPTAG && paddr[1:0] == 2'b00)
      |=> (prdata == 32'h00000010))
    else $error("capability tag wrong");

  a_capnext_fixed: assert property (@(posedge mclk) disable iff (sys_rst)
    (setup_rd && !pwrite && widx == IDX_CAPNEXT && paddr[1:0] == 2'b00)
      |=> (prdata == 32'h0000006C))
    else $error("next item pointer wrong");

  a_cap_version: assert property (@(posedge mclk) disable iff (sys_rst)
    (setup_rd && !pwrite && widx == IDX_CAPINFO && paddr[1:0] == 2'b00)
      |=> (prdata[3:0] == 4'h1))
    else $error("capability version wrong");

  a_cap_tail: assert property (@(posedge mclk) disable iff (sys_rst)
    (setup_rd && !pwrite && widx == IDX_CAPINFO && paddr[1:0] == 2'b00)
      |=> (prdata == 32'h00000001))
    else $error("capability info word wrong");

  a_fixed_write: assert property (@(posedge mclk) disable iff (sys_rst)
    (access_wr && !wr_mwin && !wr_subsys && !wr_legacy)
      |=> ($stable(mwin_q) && $stable(subsys_q) && $stable(legacy_q)))
    else $error("write to fixed word changed state");

  // main scenarios seen at least once
  // the both-paths cover is the only one that exercises offset priority
  c_subsys_locked: cover property (@(posedge mclk) disable iff (sys_rst)
    subsys_done_q && wr_subsys);
  c_legacy_hit: cover property (@(posedge mclk) disable iff (sys_rst)
    route.legacy);
  c_window_hit: cover property (@(posedge mclk) disable iff (sys_rst)
    route.window);
  c_both_hit: cover property (@(posedge mclk) disable iff (sys_rst)
    route.legacy && route.window);
  c_unmapped: cover property (@(posedge mclk) disable iff (sys_rst)
    pslverr);

endmodule

// ===== acfh_rc_model.sv
`timescale 1ns/1ps
// stand-in for the link requester: one memory request per call
module acfh_rc_model
  import acfh_pkg::*;
(
  input  wire logic mclk,  // core clock
  output acfh_mreq_t mreq  // memory request toward the decoder
);
  // idle at time zero, no request pending
  initial mreq = '0;

  // request launched just after an edge, held for exactly one cycle
  task automatic send(input logic [31:0] addr);
    @(posedge mclk);
    mreq.valid <= 1'b1;
    mreq.addr  <= addr;
    @(posedge mclk);
    // a released address must not look stable, so show its inverse
    mreq.valid <= 1'b0;
    mreq.addr  <= ~addr;
  endtask
endmodule

// ===== apic_function_config_header_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module apic_function_config_header_test
  import acfh_pkg::*;
;
  logic              mclk;        // core clock
  logic              sys_rst;     // primary bus reset
  logic              psel;        // apb select
  logic              penable;     // apb access phase
  logic              pwrite;      // apb direction
  logic [ADDR_W-1:0] paddr;       // apb byte address
  logic [31:0]       pwdata;      // apb write data
  logic [3:0]        pstrb;       // apb byte strobes
  logic [31:0]       prdata;      // apb read data
  logic              pready;      // apb ready
  logic              pslverr;     // apb error
  acfh_mreq_t        mreq;        // request from the requester model
  acfh_route_t       route;       // claim decision
  int                fail_count;  // mismatches seen
  int                checked;     // comparisons made
  int                cyc;         // cycles since start
  logic [31:0]       rd;          // last read data
  logic              err;         // last error flag
  logic [3:0]        strb;        // byte strobes for the next transfer

  acfh_config_header uut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mreq(mreq), .route(route));
  acfh_rc_model rc (.mclk(mclk), .mreq(mreq));

  // 50 MHz core clock
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // byte address is four times the printed offset
  function automatic logic [ADDR_W-1:0] ba(input logic [6:0] idx);
    return {3'h0, idx, 2'h0};
  endfunction

  // one apb transfer; data taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // pready is read at each rising edge, before the design updates it there
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read and compare, with no error expected
  task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h00000000);
    `CHK(nm, ex, rd)
    `CHK("pslverr", 1'b0, err)
  endtask

  // one memory request, decision checked the cycle after
  task automatic rt(input logic [31:0] a, input logic h, l, w, input logic [11:0] off);
    rc.send(a);
    #1;
    `CHK("hit", h, route.hit)
    `CHK("legacy", l, route.legacy)
    `CHK("window", w, route.window)
    if (h) `CHK("offset", off, route.offset)
  endtask

  // one fixed word: read, write all ones, read again
  task automatic fix1(input logic [6:0] idx, input logic [31:0] v);
    rchk("fixed", ba(idx), v);
    apb(1'b1, ba(idx), 32'hFFFFFFFF);
    rchk("fixed", ba(idx), v);
  endtask

  // fixed bytes ignore writes; unmapped address is refused
  task automatic t_fixed();
    fix1(IDX_LAT, 32'h00000000);
    fix1(IDX_HDR, 32'h00000000);
    fix1(IDX_TEST, 32'h00000000);
    fix1(IDX_CAPHEAD, 32'h00000044);
    fix1(IDX_CAPTAG, 32'h00000010);
    fix1(IDX_CAPNEXT, 32'h0000006C);
    fix1(IDX_CAPINFO, 32'h00000001);
    apb(1'b0, 12'h004, 32'h00000000);
    `CHK("unmapped err", 1'b1, err)
    $display("test fixed done");
  endtask

  // window base: only bits 31:12 hold, and it decodes
  task automatic t_window();
    rchk("window", ba(IDX_MWIN), 32'h00000000);
    apb(1'b1, ba(IDX_MWIN), 32'hFFFFFFFF);
    rchk("window", ba(IDX_MWIN), 32'hFFFFF000);
    strb = 4'h4;
    apb(1'b1, ba(IDX_MWIN), 32'h00A50000);
    strb = 4'hF;
    rchk("window", ba(IDX_MWIN), 32'hFFA5F000);
    apb(1'b1, ba(IDX_MWIN), 32'hFECA5ABC);
    rchk("window", ba(IDX_MWIN), 32'hFECA5000);
    rt(32'hFECA5123, 1'b1, 1'b0, 1'b1, 12'h123);
    rt(32'hFECA6123, 1'b0, 1'b0, 1'b0, 12'h000);
    $display("test window done");
  endtask

  // legacy range: enable, digit fields, boundaries, overlap with the window
  task automatic t_legacy();
    rchk("legacy", ba(IDX_LEGACY), 32'h00000000);
    apb(1'b1, ba(IDX_LEGACY), 32'h00007FFF);
    rchk("legacy", ba(IDX_LEGACY), 32'h00000FFF);
    rt(32'hFECFFF40, 1'b0, 1'b0, 1'b0, 12'h000);
    apb(1'b1, ba(IDX_LEGACY), 32'h00008B6D);
    rchk("legacy", ba(IDX_LEGACY), 32'h00008B6D);
    rt(32'hFECB6D00, 1'b1, 1'b1, 1'b0, 12'h000);
    rt(32'hFECB6DFF, 1'b1, 1'b1, 1'b0, 12'h0FF);
    rt(32'hFECB6E00, 1'b0, 1'b0, 1'b0, 12'h000);
    rt(32'hFECA6D00, 1'b0, 1'b0, 1'b0, 12'h000);
    rt(32'hFDCB6D00, 1'b0, 1'b0, 1'b0, 12'h000);
    apb(1'b1, ba(IDX_LEGACY), 32'h00008A50);
    rt(32'hFECA5034, 1'b1, 1'b1, 1'b1, 12'h034);
    $display("test legacy done");
  endtask

  // write-once identifier, then a bus reset in mid-run
  task automatic t_subsys();
    rchk("subsys", ba(IDX_SUBSYS), 32'h00000000);
    apb(1'b1, ba(IDX_SUBSYS), 32'h5A5AC3C3);
    rchk("subsys", ba(IDX_SUBSYS), 32'h5A5AC3C3);
    apb(1'b1, ba(IDX_SUBSYS), 32'h12345678);
    rchk("subsys", ba(IDX_SUBSYS), 32'h5A5AC3C3);
    @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    rchk("subsys", ba(IDX_SUBSYS), 32'h00000000);
    rchk("legacy", ba(IDX_LEGACY), 32'h00000000);
    rt(32'hFECA5034, 1'b0, 1'b0, 1'b0, 12'h000);
    apb(1'b1, ba(IDX_SUBSYS), 32'h12345678);
    rchk("subsys", ba(IDX_SUBSYS), 32'h12345678);
    $display("test subsys done");
  endtask

  // single place where the run ends
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch; the whole run needs well under this
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // reset held three cycles, then the scenarios in turn
  initial begin
    fail_count = 0;
    checked = 0;
    cyc = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    strb = 4'hF;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_fixed();
    t_window();
    t_legacy();
    t_subsys();
    tally_and_finish();
  end
endmodule
